//--- common/pasd_if.sv
// Carriers between the decoder and its two helper modules.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface pasd_rd_if #(parameter int unsigned ADDR_W = 32);
  logic              start;
  logic [ADDR_W-1:0] addr;
  logic              done;
  logic [31:0]       data;
  modport client (output start, output addr, input done, input data);
  modport server (input start, input addr, output done, output data);
endinterface // pasd_rd_if

interface pasd_loop_if;
  logic       load;
  logic [2:0] code;
  logic [4:0] chan;
  modport source (output load, output code, output chan);
  modport sink   (input load, input code, input chan);
endinterface // pasd_loop_if

//--- common/pasd_pkg.sv
// Shared constants and types of the action specification decoder.
// Assumes 32-bit words in host memory and word-aligned control blocks.
package pasd_pkg;
  localparam int unsigned WORD_BYTES     = 4;
  localparam int unsigned CH_W           = 5;
  localparam int unsigned SPEC_IDX_W     = 2;
  // Command word fields.
  localparam int unsigned CMD_ZERO_LSB   = 16;
  localparam int unsigned CMD_FULL_BIT   = 15;
  localparam int unsigned CMD_CHONLY_BIT = 14;
  localparam int unsigned CMD_CH_LSB     = 8;
  localparam int unsigned CMD_GREINIT_BIT = 6;
  localparam int unsigned CMD_SCOPE_BIT  = 5;
  localparam int unsigned CMD_EXT_BIT    = 4;
  localparam int unsigned CMD_INT_BIT    = 3;
  localparam int unsigned CMD_ATTN_BIT   = 2;
  localparam int unsigned LB_CHN_BIT     = 8;
  // Serial core control block, in words.
  localparam int unsigned CB_CMD_WORDS   = 1;
  localparam int unsigned CB_RSV_WORDS   = 2;
  localparam int unsigned CB_TSA_WORDS   = 32;
  localparam int unsigned CB_SPEC_WORDS  = 128;
  localparam int unsigned CB_RXD_WORDS   = 32;
  localparam int unsigned CB_TXD_WORDS   = 32;
  localparam int unsigned CB_TSA_OFS     = CB_CMD_WORDS + CB_RSV_WORDS;
  localparam int unsigned CB_SPEC_OFS    = CB_TSA_OFS + CB_TSA_WORDS;
  localparam int unsigned CB_RXD_OFS     = CB_SPEC_OFS + CB_SPEC_WORDS;
  localparam int unsigned CB_TXD_OFS     = CB_RXD_OFS + CB_RXD_WORDS;
  localparam int unsigned NUM_CH         = 32;
  localparam int unsigned SPEC_PER_CH    = CB_SPEC_WORDS / NUM_CH;
  // Local-bus control block, in words.
  localparam int unsigned LB_CMD_WORDS   = 1;
  localparam int unsigned LB_SPEC_WORDS  = 4;
  localparam int unsigned LB_RXD_WORDS   = 2;
  localparam int unsigned LB_TXD_WORDS   = 2;
  localparam int unsigned LB_SPEC_OFS    = LB_CMD_WORDS;
  localparam int unsigned LB_NUM_CH      = 2;
  localparam int unsigned LB_SPEC_PER_CH = LB_SPEC_WORDS / LB_NUM_CH;
  // Loop codes, ordered {scope, external, internal}.
  localparam logic [2:0] LCODE_NONE  = 3'h0;
  localparam logic [2:0] LCODE_CINT  = 3'h1;
  localparam logic [2:0] LCODE_CEXT  = 3'h2;
  localparam logic [2:0] LCODE_OFF   = 3'h3;
  localparam logic [2:0] LCODE_BAD0  = 3'h4;
  localparam logic [2:0] LCODE_CHINT = 3'h5;
  localparam logic [2:0] LCODE_CHEXT = 3'h6;
  localparam logic [2:0] LCODE_BAD1  = 3'h7;
  typedef enum logic [2:0] {
    PASD_LOOP_OFF, PASD_LOOP_CINT, PASD_LOOP_CEXT, PASD_LOOP_CHINT, PASD_LOOP_CHEXT
  } pasd_loop_type;
  // Reset values.
  localparam pasd_loop_type RST_LOOP_MODE = PASD_LOOP_OFF;
  localparam logic [31:0]   RST_WORD      = 32'h0000_0000;
  localparam logic [4:0]    RST_CH        = 5'h00;
  localparam logic [7:0]    RST_IDX       = 8'h00;
  localparam logic          RST_BIT       = 1'b0;
endpackage

//--- hw/pasd_decoder.sv
// Action specification decoder: fetches and executes host commands.
// Assumes host software fills the control blocks before raising a request.
//
// Operation
// - One command word fetch per action request from either request bit.
// - Each action happens only when its own command bit is one.
// - Core block: command, 2 reserved, 32 slot, 128 spec, 32+32 descriptors.
// - Local block: command, 4 spec words, 2 plus 2 descriptor addresses.
// - Full init reads all slot words and the numbered channel's spec.
// - Channel-only init reads the numbered channel's spec, slots untouched.
// - Global reinit loads all slots and every channel spec.
// - Attention bit clears the interrupt queue counter.
// - Loop bits decode to none, complete, channelwise, off or illegal.
// - Complete external loop sends serial input back out.
// - Complete internal loop feeds output to input, pin ignored.
// - Channelwise external loop reflects the chosen channel input to output.
// - Channelwise internal loop reflects the chosen channel output to input.
`timescale 1ns/1ps
module pasd_decoder #(
  parameter int unsigned ADDR_W = 32
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Action request pulses from the command register.
  input  wire logic                    serial_core_action_request,
  input  wire logic                    local_bus_action_request,
  // Control block base byte addresses.
  input  wire logic [ADDR_W-1:0]       control_config_block_base,
  input  wire logic [ADDR_W-1:0]       local_bus_config_block_base,
  // Host memory read port.
  output logic                         mem_rd_req,
  output logic [ADDR_W-1:0]            mem_addr,
  input  wire logic                    mem_rd_ack,
  input  wire logic [31:0]             mem_rd_data,
  // Writes into the channel state store.
  output logic                         tsa_wr,
  output logic [pasd_pkg::CH_W-1:0]    tsa_idx,
  output logic                         spec_wr,
  output logic                         spec_lb,
  output logic [pasd_pkg::CH_W-1:0]    spec_ch,
  output logic [pasd_pkg::SPEC_IDX_W-1:0] spec_word,
  output logic [31:0]                  cfg_data,
  // Interrupt queue counter clears.
  output logic                         irq_cnt_clr,
  output logic                         lb_irq_cnt_clr,
  // Status.
  output logic                         busy,
  output logic                         cmd_reject,
  output logic                         action_done,
  // Serial data paths and loop state.
  input  wire logic                    ser_rx_pin,
  input  wire logic                    core_tx_data,
  output logic                         ser_tx_pin,
  output logic                         core_rx_data,
  output pasd_pkg::pasd_loop_type      loop_mode,
  output logic [pasd_pkg::CH_W-1:0]    loop_chan,
  output logic                         chan_loop_int,
  output logic                         chan_loop_ext
);
  import pasd_pkg::*;

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must lie between 12 and 32.");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DEC, ST_TSA, ST_SPEC} pasd_state_type;

  pasd_state_type    state_r;
  pasd_state_type    state_nxt;
  logic              pend_core_r;
  logic              pend_lb_r;
  logic              src_lb_r;
  logic              src_lb_nxt;
  logic              all_r;
  logic              all_nxt;
  logic              wait_r;
  logic [7:0]        idx_r;
  logic [7:0]        idx_nxt;
  logic [31:0]       cmd_r;
  logic              tsa_wr_r;
  logic [CH_W-1:0]   tsa_idx_r;
  logic              spec_wr_r;
  logic              spec_lb_r;
  logic [CH_W-1:0]   spec_ch_r;
  logic [SPEC_IDX_W-1:0] spec_word_r;
  logic [31:0]       cfg_data_r;
  logic              irq_clr_r;
  logic              lb_irq_clr_r;
  logic              reject_r;
  logic              done_r;

  pasd_rd_if #(.ADDR_W(ADDR_W)) rd ();
  pasd_loop_if                  lp ();

  wire logic         take_core;
  wire logic         take_lb;
  assign take_core = (state_r == ST_IDLE) & pend_core_r;
  assign take_lb   = (state_r == ST_IDLE) & pend_lb_r & ~pend_core_r;

  wire logic         full_init_flag;
  wire logic         channel_only_init_flag;
  wire logic         global_reinit_flag;
  wire logic         irq_queue_attention;
  wire logic         loop_scope_select;
  wire logic         loop_external_select;
  wire logic         loop_internal_select;
  wire logic [2:0]   loop_code;
  wire logic [CH_W-1:0] cmd_ch;
  wire logic         loop_bad;
  wire logic         init_multi;
  wire logic         cmd_illegal;
  wire logic         in_dec;
  wire logic         dec_ok;

  // The local-bus word has no full init, global reinit or loop fields.
  assign full_init_flag         = cmd_r[CMD_FULL_BIT] & ~src_lb_r;
  assign channel_only_init_flag = cmd_r[CMD_CHONLY_BIT];
  assign global_reinit_flag     = cmd_r[CMD_GREINIT_BIT] & ~src_lb_r;
  assign irq_queue_attention    = cmd_r[CMD_ATTN_BIT];
  assign loop_scope_select      = cmd_r[CMD_SCOPE_BIT] & ~src_lb_r;
  assign loop_external_select   = cmd_r[CMD_EXT_BIT] & ~src_lb_r;
  assign loop_internal_select   = cmd_r[CMD_INT_BIT] & ~src_lb_r;
  assign loop_code = {loop_scope_select, loop_external_select, loop_internal_select};
  assign cmd_ch = src_lb_r ? {4'h0, cmd_r[LB_CHN_BIT]} : cmd_r[CMD_CH_LSB +: CH_W];
  assign loop_bad   = (loop_code == LCODE_BAD0) | (loop_code == LCODE_BAD1);
  assign init_multi = (full_init_flag & channel_only_init_flag)
                    | (full_init_flag & global_reinit_flag)
                    | (channel_only_init_flag & global_reinit_flag);
  assign cmd_illegal = loop_bad | init_multi;
  assign in_dec      = (state_r == ST_DEC);
  assign dec_ok      = in_dec & ~cmd_illegal;

  // Fetch address generation.
  wire logic         fetching;
  wire logic [7:0]   spec_cnt;
  wire logic [8:0]   spec_first;
  wire logic [8:0]   word_ofs;
  wire logic [ADDR_W-1:0] blk_base;
  wire logic         last_tsa;
  wire logic         last_spec;

  assign fetching = (state_r == ST_CMD) | (state_r == ST_TSA) | (state_r == ST_SPEC);
  assign spec_cnt = src_lb_r ? 8'(LB_SPEC_PER_CH)
                  : (all_r ? 8'(CB_SPEC_WORDS) : 8'(SPEC_PER_CH));
  assign spec_first = src_lb_r ? 9'(LB_SPEC_OFS) + 9'(cmd_ch) * 9'(LB_SPEC_PER_CH)
                    : (all_r ? 9'(CB_SPEC_OFS)
                             : 9'(CB_SPEC_OFS) + 9'(cmd_ch) * 9'(SPEC_PER_CH));
  assign word_ofs = (state_r == ST_TSA)  ? 9'(CB_TSA_OFS) + {1'b0, idx_r}
                  : (state_r == ST_SPEC) ? spec_first + {1'b0, idx_r}
                  : 9'h000;
  // Low address bits are dropped; the host keeps the bases word aligned.
  assign blk_base = src_lb_r ? {local_bus_config_block_base[ADDR_W-1:2], 2'b00}
                             : {control_config_block_base[ADDR_W-1:2], 2'b00};
  assign rd.start = fetching & ~wait_r;
  assign rd.addr  = blk_base + ADDR_W'({word_ofs, 2'b00});
  assign last_tsa  = (idx_r == 8'(CB_TSA_WORDS - 1));
  assign last_spec = (idx_r == spec_cnt - 8'h01);

  // Loop commands only come from the core word and only when legal.
  assign lp.load = dec_ok & (loop_code != LCODE_NONE);
  assign lp.code = loop_code;
  assign lp.chan = cmd_ch;

  always_comb begin
    state_nxt  = state_r;
    idx_nxt    = idx_r;
    all_nxt    = all_r;
    src_lb_nxt = src_lb_r;
    case (state_r)
      ST_IDLE: begin
        if (take_core) begin
          src_lb_nxt = 1'b0;
          state_nxt  = ST_CMD;
        end else if (take_lb) begin
          src_lb_nxt = 1'b1;
          state_nxt  = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rd.done) begin
          state_nxt = ST_DEC;
        end
      end
      ST_DEC: begin
        idx_nxt = RST_IDX;
        all_nxt = global_reinit_flag;
        if (cmd_illegal) begin
          state_nxt = ST_IDLE;
        end else if (full_init_flag || global_reinit_flag) begin
          state_nxt = ST_TSA;
        end else if (channel_only_init_flag) begin
          state_nxt = ST_SPEC;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TSA: begin
        if (rd.done) begin
          if (last_tsa) begin
            idx_nxt   = RST_IDX;
            state_nxt = ST_SPEC;
          end else begin
            idx_nxt = idx_r + 8'h01;
          end
        end
      end
      ST_SPEC: begin
        if (rd.done) begin
          if (last_spec) begin
            state_nxt = ST_IDLE;
          end else begin
            idx_nxt = idx_r + 8'h01;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r  <= ST_IDLE;
      idx_r    <= RST_IDX;
      all_r    <= RST_BIT;
      src_lb_r <= RST_BIT;
    end else begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      all_r    <= all_nxt;
      src_lb_r <= src_lb_nxt;
    end
  end

  // A new request wins over the take in the same cycle, so none is lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_core_r <= RST_BIT;
      pend_lb_r   <= RST_BIT;
    end else begin
      pend_core_r <= serial_core_action_request | (pend_core_r & ~take_core);
      pend_lb_r   <= local_bus_action_request | (pend_lb_r & ~take_lb);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= RST_BIT;
      cmd_r  <= RST_WORD;
    end else begin
      wait_r <= (wait_r & ~rd.done) | rd.start;
      if ((state_r == ST_CMD) && rd.done) begin
        cmd_r <= rd.data;
      end
    end
  end

  // Store writes carry the fetched word one cycle after it arrives.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tsa_wr_r    <= RST_BIT;
      spec_wr_r   <= RST_BIT;
      tsa_idx_r   <= RST_CH;
      spec_lb_r   <= RST_BIT;
      spec_ch_r   <= RST_CH;
      spec_word_r <= '0;
      cfg_data_r  <= RST_WORD;
    end else begin
      tsa_wr_r  <= (state_r == ST_TSA) & rd.done;
      spec_wr_r <= (state_r == ST_SPEC) & rd.done;
      if (rd.done && (state_r != ST_CMD)) begin
        tsa_idx_r   <= idx_r[CH_W-1:0];
        spec_lb_r   <= src_lb_r;
        spec_ch_r   <= all_r ? idx_r[CH_W+SPEC_IDX_W-1:SPEC_IDX_W] : cmd_ch;
        spec_word_r <= idx_r[SPEC_IDX_W-1:0];
        cfg_data_r  <= rd.data;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_clr_r    <= RST_BIT;
      lb_irq_clr_r <= RST_BIT;
      reject_r     <= RST_BIT;
      done_r       <= RST_BIT;
    end else begin
      irq_clr_r    <= dec_ok & irq_queue_attention & ~src_lb_r;
      lb_irq_clr_r <= dec_ok & irq_queue_attention & src_lb_r;
      reject_r     <= in_dec & cmd_illegal;
      done_r       <= (state_r != ST_IDLE) & (state_nxt == ST_IDLE);
    end
  end

  assign tsa_wr         = tsa_wr_r;
  assign tsa_idx        = tsa_idx_r;
  assign spec_wr        = spec_wr_r;
  assign spec_lb        = spec_lb_r;
  assign spec_ch        = spec_ch_r;
  assign spec_word      = spec_word_r;
  assign cfg_data       = cfg_data_r;
  assign irq_cnt_clr    = irq_clr_r;
  assign lb_irq_cnt_clr = lb_irq_clr_r;
  assign cmd_reject     = reject_r;
  assign action_done    = done_r;
  assign busy           = (state_r != ST_IDLE) | pend_core_r | pend_lb_r;

  pasd_word_reader #(
    .ADDR_W      (ADDR_W)
  ) u_reader (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rd          (rd.server),
    .mem_rd_req  (mem_rd_req),
    .mem_addr    (mem_addr),
    .mem_rd_ack  (mem_rd_ack),
    .mem_rd_data (mem_rd_data)
  );

  pasd_loop_router u_loop (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .lp            (lp.sink),
    .ser_rx_pin    (ser_rx_pin),
    .core_tx_data  (core_tx_data),
    .ser_tx_pin    (ser_tx_pin),
    .core_rx_data  (core_rx_data),
    .loop_mode     (loop_mode),
    .loop_chan     (loop_chan),
    .chan_loop_int (chan_loop_int),
    .chan_loop_ext (chan_loop_ext)
  );
endmodule // pasd_decoder

//--- hw/pasd_loop_router.sv
// Test loop state and serial data routing.
// Assumes the serial input pin is asynchronous to clk.
`timescale 1ns/1ps
module pasd_loop_router (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Loop commands from the decoder.
  pasd_loop_if.sink              lp,
  // Serial data paths.
  input  wire logic              ser_rx_pin,
  input  wire logic              core_tx_data,
  output logic                   ser_tx_pin,
  output logic                   core_rx_data,
  // Loop state towards the channel logic.
  output pasd_pkg::pasd_loop_type loop_mode,
  output logic [4:0]             loop_chan,
  output logic                   chan_loop_int,
  output logic                   chan_loop_ext
);
  import pasd_pkg::*;
  pasd_loop_type mode_r;
  pasd_loop_type mode_nxt;
  logic [4:0]    chan_r;
  logic          sync1_r;
  logic          sync2_r;
  logic          sync3_r;
  logic          rx_filt_r;
  logic          tx_r;
  logic          rx_r;
  always_comb begin
    mode_nxt = mode_r;
    case (lp.code)
      LCODE_CINT:  mode_nxt = PASD_LOOP_CINT;
      LCODE_CEXT:  mode_nxt = PASD_LOOP_CEXT;
      LCODE_OFF:   mode_nxt = PASD_LOOP_OFF;
      LCODE_CHINT: mode_nxt = PASD_LOOP_CHINT;
      LCODE_CHEXT: mode_nxt = PASD_LOOP_CHEXT;
      default:     mode_nxt = mode_r;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= RST_LOOP_MODE;
      chan_r <= RST_CH;
    end else if (lp.load) begin
      mode_r <= mode_nxt;
      chan_r <= lp.chan;
    end
  end
  // A pin change is taken only once two synchronised samples agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r   <= RST_BIT;
      sync2_r   <= RST_BIT;
      sync3_r   <= RST_BIT;
      rx_filt_r <= RST_BIT;
    end else begin
      sync1_r <= ser_rx_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        rx_filt_r <= sync3_r;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_r <= RST_BIT;
      rx_r <= RST_BIT;
    end else begin
      tx_r <= (mode_r == PASD_LOOP_CEXT) ? rx_filt_r : core_tx_data;
      rx_r <= (mode_r == PASD_LOOP_CINT) ? core_tx_data : rx_filt_r;
    end
  end
  assign ser_tx_pin    = tx_r;
  assign core_rx_data  = rx_r;
  assign loop_mode     = mode_r;
  assign loop_chan     = chan_r;
  assign chan_loop_int = (mode_r == PASD_LOOP_CHINT);
  assign chan_loop_ext = (mode_r == PASD_LOOP_CHEXT);
endmodule // pasd_loop_router

//--- hw/pasd_word_reader.sv
// Single-word reader of host memory for the decoder.
// Assumes the memory port answers each held request with one ack pulse.
`timescale 1ns/1ps
module pasd_word_reader #(
  parameter int unsigned ADDR_W = 32
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Requests from the decoder.
  pasd_rd_if.server              rd,
  // Host memory read port.
  output logic                   mem_rd_req,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic              mem_rd_ack,
  input  wire logic [31:0]       mem_rd_data
);
  import pasd_pkg::*;
  logic              req_r;
  logic              done_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0]       data_r;
  wire logic         got;
  assign got = req_r & mem_rd_ack;
  // The request stays up until acked, so a slow memory never loses a word.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_r  <= RST_BIT;
      done_r <= RST_BIT;
      addr_r <= '0;
      data_r <= RST_WORD;
    end else begin
      done_r <= got;
      if (got) begin
        req_r  <= 1'b0;
        data_r <= mem_rd_data;
      end else if (rd.start && !req_r) begin
        req_r  <= 1'b1;
        addr_r <= rd.addr;
      end
    end
  end
  assign mem_rd_req = req_r;
  assign mem_addr   = addr_r;
  assign rd.done    = done_r;
  assign rd.data    = data_r;
endmodule // pasd_word_reader

//--- verification/pasd_decoder_asserts.sv
// Concurrent checks on the decoder's top ports.
// Assumes one clock domain and the active high asynchronous reset.
`timescale 1ns/1ps
module pasd_decoder_asserts
  import pasd_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic                clk, sys_rst, serial_core_action_request, busy,
  input wire logic [ADDR_W-1:0]   control_config_block_base, mem_addr,
  input wire logic                mem_rd_req, mem_rd_ack, tsa_wr, spec_wr, spec_lb,
  input wire logic [31:0]         mem_rd_data, cfg_data,
  input wire logic [CH_W-1:0]     spec_ch,
  input wire logic [SPEC_IDX_W-1:0] spec_word,
  input wire logic                irq_cnt_clr, lb_irq_cnt_clr, cmd_reject,
  input wire logic                core_tx_data, ser_tx_pin, core_rx_data, chan_loop_ext,
  input wire pasd_loop_type       loop_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_fetch;
    serial_core_action_request && !busy |-> ##[2:4]
      (mem_rd_req && mem_addr == {control_config_block_base[ADDR_W-1:2], 2'b00});
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch");
  property p_hold;
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  property p_gap;
    mem_rd_req && mem_rd_ack |=> !mem_rd_req;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_slot;
    tsa_wr |-> $past(mem_rd_ack, 2) && cfg_data == $past(mem_rd_data, 2) && !spec_wr;
  endproperty
  a_slot: assert property (p_slot) else $error("slot data");
  property p_spec;
    spec_wr |-> $past(mem_rd_ack, 2) && cfg_data == $past(mem_rd_data, 2);
  endproperty
  a_spec: assert property (p_spec) else $error("spec data");
  property p_lb_spec;
    spec_wr && spec_lb |-> spec_ch <= 5'h01 && spec_word <= 2'h1;
  endproperty
  a_lb_spec: assert property (p_lb_spec) else $error("lb index");
  property p_reject;
    cmd_reject |-> $stable(loop_mode) && !tsa_wr && !spec_wr && !irq_cnt_clr && !lb_irq_cnt_clr;
  endproperty
  a_reject: assert property (p_reject) else $error("reject acted");
  property p_int_loop;
    !$past(sys_rst) && $past(loop_mode) == PASD_LOOP_CINT |-> core_rx_data == $past(core_tx_data);
  endproperty
  a_int_loop: assert property (p_int_loop) else $error("int loop");
  property p_tx_path;
    !$past(sys_rst) && $past(loop_mode) != PASD_LOOP_CEXT |-> ser_tx_pin == $past(core_tx_data);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx path");
  c_reject: cover property (cmd_reject);
  c_global: cover property (spec_wr && spec_ch == 5'h1F);
  c_chan_ext: cover property (chan_loop_ext);
endmodule // pasd_decoder_asserts
bind pasd_decoder pasd_decoder_asserts #(.ADDR_W(ADDR_W)) u_pasd_decoder_asserts (.*);

//--- verification/pasd_decoder_tb_top.sv
// Bench of the decoder with a host memory model.
// Assumes the design package and carriers are compiled first.
`timescale 1ns/1ps
module pasd_decoder_tb_top;
  import pasd_pkg::*;
  localparam logic [31:0] CB = 32'h0000_1000, LB = 32'h0000_2000;
  logic clk = 1'b0, sys_rst = 1'b1, serial_core_action_request = 1'b0;
  logic local_bus_action_request = 1'b0, ser_rx_pin = 1'b0, core_tx_data = 1'b0;
  logic [31:0] cmd_word = 32'h0000_0000, mem_addr, mem_rd_data, cfg_data;
  logic [1:0] lat = 2'h0, spec_word;
  logic [4:0] tsa_idx, spec_ch, loop_chan;
  logic mem_rd_req, mem_rd_ack, tsa_wr, spec_wr, spec_lb, irq_cnt_clr, lb_irq_cnt_clr, busy;
  logic cmd_reject, action_done, ser_tx_pin, core_rx_data, chan_loop_int, chan_loop_ext;
  pasd_loop_type loop_mode;
  int n_errors = 0, total_checks = 0, cyc = 0;
  logic [2:0] codes [5] = '{LCODE_CINT, LCODE_CEXT, LCODE_CHINT, LCODE_CHEXT, LCODE_OFF};
  pasd_loop_type modes [5] = '{PASD_LOOP_CINT, PASD_LOOP_CEXT, PASD_LOOP_CHINT,
                               PASD_LOOP_CHEXT, PASD_LOOP_OFF};
  pasd_decoder u_pasd_decoder (.*, .control_config_block_base(CB),
    .local_bus_config_block_base(LB));
  pasd_host_mem u_pasd_host_mem (.*);
  always #25 clk = ~clk;
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  function automatic logic [31:0] cw(input logic f, c, input logic [4:0] ch,
                                     input logic g, input logic [2:0] lp, input logic ia);
    return {16'h0000, f, c, 1'b0, ch, 1'b0, g, lp, ia, 2'b00};
  endfunction
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      $display("MISMATCH %0t %s", $time, m);
      n_errors++;
    end
  endtask
  // One request; tallies stores, clears and rejects.
  task automatic cmd(input logic lb, input logic [31:0] w, input int et, es, ei, er);
    int nt, ns, ni, nr, nc, nf, t;
    logic [4:0] ch;
    {nt, ns, ni, nr, nc, nf} = '0;
    ch = lb ? {4'h0, w[8]} : w[12:8];
    cmd_word = w;
    {serial_core_action_request, local_bus_action_request} = {!lb, lb};
    @(posedge clk) #1 {serial_core_action_request, local_bus_action_request} = 2'b00;
    for (t = 0; t < 3000; t++) begin
      if (mem_rd_ack && mem_addr === (lb ? LB : CB)) nf++;
      if (tsa_wr === 1'b1) begin
        nt++;
        chk(cfg_data === pat(CB + 12 + 4 * tsa_idx), "slot word");
      end
      if (spec_wr === 1'b1) begin
        ns++;
        nc += int'(spec_ch === ch);
        chk(cfg_data === pat(lb ? LB + 4 + 8 * spec_ch + 4 * spec_word
                                : CB + 140 + 16 * spec_ch + 4 * spec_word), "spec word");
      end
      ni += int'((lb ? lb_irq_cnt_clr : irq_cnt_clr) === 1'b1);
      nr += int'(cmd_reject === 1'b1);
      if (action_done === 1'b1) break;
      @(posedge clk) #1;
    end
    chk(nf == 1 && nt == et && ns == es && ni == ei && nr == er, "counts");
    chk(nc == (es == 0 ? 0 : (lb ? 2 : 4)), "spec ch");
    $display("command %h done", w);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    ser_rx_pin = 1'b1;
    cmd(0, cw(0, 0, 0, 0, LCODE_NONE, 1), 0, 0, 1, 0);
    lat = 2'h3;
    cmd(0, cw(1, 0, 5, 0, LCODE_NONE, 0), 32, 4, 0, 0);
    lat = 2'h0;
    cmd(0, cw(0, 1, 31, 0, LCODE_NONE, 0), 0, 4, 0, 0);
    cmd(0, cw(0, 0, 0, 1, LCODE_NONE, 0), 32, 128, 0, 0);
    cmd(1, 32'h0000_4104, 0, 2, 1, 0);
    for (int i = 0; i < 5; i++) begin
      cmd(0, cw(0, 0, 7, 0, codes[i], 0), 0, 0, 0, 0);
      repeat (8) @(posedge clk);
      #1 chk(loop_mode === modes[i], "loop mode");
      if (i == 0) chk(core_rx_data === 1'b0, "int loop");
      if (i == 1) chk(ser_tx_pin === 1'b1, "ext loop");
      if (i == 2) chk(chan_loop_int === 1'b1 && loop_chan === 5'h07, "chan int");
      if (i == 3) begin
        chk(chan_loop_ext === 1'b1 && loop_chan === 5'h07, "chan ext");
        cmd(0, cw(0, 0, 2, 0, LCODE_BAD0, 1), 0, 0, 0, 1);
        cmd(0, cw(0, 0, 2, 0, LCODE_BAD1, 0), 0, 0, 0, 1);
        cmd(0, cw(1, 1, 2, 0, LCODE_NONE, 0), 0, 0, 0, 1);
        chk(loop_mode === PASD_LOOP_CHEXT && loop_chan === 5'h07, "loop kept");
      end
    end
    cmd(0, 32'h0000_0000, 0, 0, 0, 0);
    chk(loop_mode === PASD_LOOP_OFF, "loops open");
    test_done();
  end
endmodule // pasd_decoder_tb_top

//--- verification/pasd_host_mem.sv
// Host memory model that answers the decoder's word reads.
// Assumes the command words sit at 4 KiB aligned block bases.
`timescale 1ns/1ps
module pasd_host_mem (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Read port.
  input  wire logic        mem_rd_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_rd_ack,
  output logic [31:0]      mem_rd_data,
  // Scenario control.
  input  wire logic [31:0] cmd_word,
  input  wire logic [1:0]  lat
);
  logic [1:0] wait_r;
  // Other words return the inverted low address half above the low address half.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= 32'h0000_0000;
      wait_r      <= 2'h0;
    end else if (mem_rd_req && !mem_rd_ack && wait_r == lat) begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= (mem_addr[11:0] == 12'h000) ? cmd_word
                     : {~mem_addr[15:0], mem_addr[15:0]};
      wait_r      <= 2'h0;
    end else begin
      // Stale data is scrambled once released.
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      wait_r      <= (mem_rd_req && !mem_rd_ack) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule // pasd_host_mem
